// File: include/byte_port_map.svh
// Register offsets, reset values and field layout of the byte port
`ifndef BYTE_PORT_MAP_SVH
`define BYTE_PORT_MAP_SVH

`define PORT_ADDR_W          20
`define PORT_WIDTH           8
`define PIN_DIRECTION_OFS    20'hee003
`define PULLUP_ENABLE_OFS    20'hee03e
`define PIN_OUTPUT_DATA_OFS  20'hfffd3
`define PORT_MODE_OFS        20'hee0f0
`define PIN_DIRECTION_RST    8'h00
`define PULLUP_ENABLE_RST    8'h00
`define PIN_OUTPUT_DATA_RST  8'h00
`define PORT_MODE_RST        8'h00
`define DIRECTION_READ_VAL   8'hff
`define UNMAPPED_READ_VAL    8'h00
`define MODE_SINGLE_CHIP_BIT 0
`define MODE_WIDE_BUS_BIT    1
`define MODE_MASK            8'h03

`endif

// File: include/byte_port_pkg.sv
// Types shared by the byte port design
package byte_port_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    OWNER_GPIO,
    OWNER_DATA_BUS,
    OWNER_STANDBY
  } pin_owner_e;

endpackage : byte_port_pkg

// File: rtl/byte_port_reg8.sv
// One 8-bit control register with reset/standby clear and write load
`timescale 1ns/1ps
`default_nettype none
module byte_port_reg8
  import byte_port_pkg::*;
#(
  parameter byte_t RESET_VAL = 8'h00
) (
  input  wire logic  i_ref_clk,  // System clock
  input  wire logic  i_clear,    // Reset or hardware standby
  input  wire logic  i_load,     // Write this register
  input  wire byte_t i_data,     // Write data
  output byte_t      o_value     // Stored value
);

  typedef struct packed {
    byte_t value_reg;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (i_load) begin
      state_next.value_reg = i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_clear) begin
      state_reg.value_reg <= RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_value = state_reg.value_reg;

endmodule : byte_port_reg8
`default_nettype wire

// File: rtl/byte_port_pin_ctrl.sv
// Per-pin output enable, output level and pull-up control
`timescale 1ns/1ps
`default_nettype none
module byte_port_pin_ctrl
  import byte_port_pkg::*;
(
  input  wire logic  i_gpio_owned,  // Port serves as GPIO
  input  wire logic  i_in_reset,    // Reset or hardware standby
  input  wire byte_t i_direction,   // Direction bits
  input  wire byte_t i_out_data,    // Output data bits
  input  wire byte_t i_pullup_en,   // Pull-up enable bits
  input  wire byte_t i_bus_oe,      // Data bus output enable
  input  wire byte_t i_bus_out,     // Data bus output level
  output byte_t      o_pin_oe,      // Pin output enable
  output byte_t      o_pin_out,     // Pin output level
  output byte_t      o_pullup_on    // Pull-up on per pin
);

  always_comb begin
    if (i_gpio_owned) begin
      o_pin_oe  = i_direction;  // RL2 RL3 RL15
      o_pin_out = i_out_data;   // RL8
    end else begin
      o_pin_oe  = i_bus_oe;     // RL4 RL15
      o_pin_out = i_bus_out;
    end
    o_pullup_on = (i_gpio_owned && !i_in_reset) ? (i_pullup_en & ~i_direction) : 8'h00;  // RL11 RL12
  end

endmodule : byte_port_pin_ctrl
`default_nettype wire

// File: rtl/byte_port.sv
// 8-bit GPIO port shared with one half of the external data bus
// Behaviour
// (RL1) Three 8-bit control registers; bit n controls pin n.
// (RL2) Single-chip: direction 1 drives pin, 0 makes it input.
// (RL3) Expanded with all areas 8-bit: port is GPIO under direction bits.
// (RL4) Expanded with any 16-bit area: pins carry data bus, direction ignored.
// (RL5) Direction register is write-only and reads all ones.
// (RL6) Reset and hardware standby clear direction; software standby keeps it.
// (RL7) GPIO outputs keep driving during software standby.
// (RL8) A GPIO output pin drives its output data bit.
// (RL9) Data read: output bit where direction 1, pin level where 0.
// (RL10) Reset and hardware standby clear output data; software standby keeps it.
// (RL11) In GPIO ownership, pull-up on when direction 0 and enable 1.
// (RL12) Pull-ups off in reset, hardware standby and 16-bit bus mode.
// (RL13) Reset and hardware standby clear pull-up enable; software standby keeps it.
// (RL14) Register addresses decode the low 20 address bits.
// (RL15) GPIO output enable is ownership AND direction; else bus controls pin.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "byte_port_map.svh"
module byte_port
  import byte_port_pkg::*;
(
  input  wire logic                     i_ref_clk,     // 40 MHz clock
  input  wire logic                     i_rst,         // Synchronous reset, active high
  input  wire logic                     i_hw_standby,  // Hardware standby, active high
  input  wire logic                     i_sw_standby,  // Software standby, active high
  input  wire logic [`PORT_ADDR_W-1:0]  i_addr,        // Register address
  input  wire byte_t                    i_wdata,       // Write data
  input  wire logic                     i_wr,          // Write strobe
  input  wire logic                     i_rd,          // Read strobe
  output byte_t                         o_rdata,       // Read data, cycle after strobe
  input  wire byte_t                    i_pin_in,      // Pin levels
  output byte_t                         o_pin_out,     // Pin drive level
  output byte_t                         o_pin_oe,      // Pin drive enable
  output byte_t                         o_pullup_on,   // Pull-up control
  input  wire byte_t                    i_bus_out,     // Data bus drive level
  input  wire byte_t                    i_bus_oe,      // Data bus drive enable
  output byte_t                         o_bus_in,      // Pin levels to data bus
  output logic                          o_gpio_owned   // Port serves as GPIO
);

  typedef struct packed {
    byte_t rdata_reg;
    byte_t mode_reg;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic  clear;
  logic  sel_dir;
  logic  sel_data;
  logic  sel_pull;
  logic  sel_mode;
  logic  gpio_owned;
  byte_t direction;
  byte_t out_data;
  byte_t pullup_en;
  byte_t port_read;

  assign clear = i_rst | i_hw_standby;  // RL6 RL10 RL13

  // Only the low 20 address bits take part in the decode
  always_comb begin
    sel_dir  = 1'b0;
    sel_data = 1'b0;
    sel_pull = 1'b0;
    sel_mode = 1'b0;
    if (i_addr == `PIN_DIRECTION_OFS) begin  // RL14
      sel_dir = 1'b1;
    end else if (i_addr == `PIN_OUTPUT_DATA_OFS) begin
      sel_data = 1'b1;
    end else if (i_addr == `PULLUP_ENABLE_OFS) begin
      sel_pull = 1'b1;
    end else if (i_addr == `PORT_MODE_OFS) begin
      sel_mode = 1'b1;
    end
  end

  // Control registers; software standby does not touch them
  byte_port_reg8 #(.RESET_VAL(`PIN_DIRECTION_RST)) u_direction (  // RL1 RL6 RL7
    .i_ref_clk (i_ref_clk),
    .i_clear   (clear),
    .i_load    (i_wr && sel_dir),
    .i_data    (i_wdata),
    .o_value   (direction)
  );

  byte_port_reg8 #(.RESET_VAL(`PIN_OUTPUT_DATA_RST)) u_out_data (  // RL10
    .i_ref_clk (i_ref_clk),
    .i_clear   (clear),
    .i_load    (i_wr && sel_data),
    .i_data    (i_wdata),
    .o_value   (out_data)
  );

  byte_port_reg8 #(.RESET_VAL(`PULLUP_ENABLE_RST)) u_pullup_en (  // RL13
    .i_ref_clk (i_ref_clk),
    .i_clear   (clear),
    .i_load    (i_wr && sel_pull),
    .i_data    (i_wdata),
    .o_value   (pullup_en)
  );

  // Single-chip or all-8-bit-areas gives the port to GPIO
  assign gpio_owned = state_reg.mode_reg[`MODE_SINGLE_CHIP_BIT] |
                      ~state_reg.mode_reg[`MODE_WIDE_BUS_BIT];  // RL3 RL4

  assign port_read = (out_data & direction) | (i_pin_in & ~direction);  // RL9

  always_comb begin
    state_next = state_reg;
    if (i_wr && sel_mode) begin
      state_next.mode_reg = i_wdata & `MODE_MASK;
    end
    state_next.rdata_reg = `UNMAPPED_READ_VAL;
    if (i_rd) begin
      if (sel_dir) begin
        state_next.rdata_reg = `DIRECTION_READ_VAL;  // RL5
      end else if (sel_data) begin
        state_next.rdata_reg = port_read;
      end else if (sel_pull) begin
        state_next.rdata_reg = pullup_en;
      end else if (sel_mode) begin
        state_next.rdata_reg = state_reg.mode_reg;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg.rdata_reg <= `UNMAPPED_READ_VAL;
      state_reg.mode_reg  <= `PORT_MODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  byte_port_pin_ctrl u_pin_ctrl (
    .i_gpio_owned (gpio_owned),
    .i_in_reset   (clear),
    .i_direction  (direction),
    .i_out_data   (out_data),
    .i_pullup_en  (pullup_en),
    .i_bus_oe     (i_bus_oe),
    .i_bus_out    (i_bus_out),
    .o_pin_oe     (o_pin_oe),
    .o_pin_out    (o_pin_out),
    .o_pullup_on  (o_pullup_on)
  );

  assign o_rdata      = state_reg.rdata_reg;
  assign o_bus_in     = i_pin_in;
  assign o_gpio_owned = gpio_owned;

endmodule : byte_port
`default_nettype wire

// File: tb/byte_port_assertions.sv
// Port-level checker for the byte port
`timescale 1ns/1ps
`default_nettype none
`include "byte_port_map.svh"
module byte_port_assertions
  import byte_port_pkg::*;
(
  input wire logic                    i_ref_clk,     // Clock
  input wire logic                    i_rst,         // Reset
  input wire logic                    i_hw_standby,  // Hw standby
  input wire logic [`PORT_ADDR_W-1:0] i_addr,        // Address
  input wire byte_t                   i_wdata,       // Write data
  input wire logic                    i_wr,          // Write
  input wire logic                    i_rd,          // Read
  input wire byte_t                   o_rdata,       // Read data
  input wire byte_t                   o_pin_out,     // Pin level
  input wire byte_t                   o_pin_oe,      // Pin enable
  input wire byte_t                   o_pullup_on,   // Pull-ups
  input wire byte_t                   i_bus_out,     // Bus level
  input wire byte_t                   i_bus_oe,      // Bus enable
  input wire logic                    o_gpio_owned   // GPIO owner
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  dir_load_a: assert property (
    i_wr && i_addr == `PIN_DIRECTION_OFS && !i_hw_standby |=> !o_gpio_owned || o_pin_oe == $past(i_wdata))
    else $error("pin enable does not follow direction write");
  data_drive_a: assert property (
    i_wr && i_addr == `PIN_OUTPUT_DATA_OFS && !i_hw_standby |=>
      !o_gpio_owned || ((o_pin_out ^ $past(i_wdata)) & o_pin_oe) == 8'h00)
    else $error("output pin level differs from written data");
  bus_follow_a: assert property (!o_gpio_owned |-> o_pin_oe == i_bus_oe && o_pin_out == i_bus_out)
    else $error("pins do not follow data bus");
  pu_forced_a: assert property (!o_gpio_owned || i_hw_standby |-> o_pullup_on == 8'h00)
    else $error("pull-up on while forced off");
  pu_input_a: assert property (o_gpio_owned |-> (o_pullup_on & o_pin_oe) == 8'h00)
    else $error("pull-up on an output pin");
  dir_read_a: assert property (i_rd && i_addr == `PIN_DIRECTION_OFS |=> o_rdata == `DIRECTION_READ_VAL)
    else $error("direction read not all ones");
  hw_clear_a: assert property (i_hw_standby |=> !o_gpio_owned || o_pin_oe == 8'h00)
    else $error("direction kept through hardware standby");
  data_read_a: assert property (
    i_rd && i_addr == `PIN_OUTPUT_DATA_OFS && o_gpio_owned |=> ((o_rdata ^ $past(o_pin_out)) & $past(o_pin_oe)) == 8'h00)
    else $error("output bit not returned on read");
  reset_state_a: assert property ($fell(i_rst) |-> o_pin_oe == 8'h00 && o_pullup_on == 8'h00)
    else $error("pins not idle after reset");
  cover property (!o_gpio_owned);
  cover property (o_pullup_on != 8'h00);
  cover property (i_rd && i_addr == `PIN_OUTPUT_DATA_OFS);
endmodule : byte_port_assertions
bind byte_port byte_port_assertions i_byte_port_assertions (.i_ref_clk, .i_rst, .i_hw_standby, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_pin_out, .o_pin_oe, .o_pullup_on, .i_bus_out, .i_bus_oe, .o_gpio_owned);
`default_nettype wire

// File: tb/byte_port_pins.sv
// Pads of the port with board drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none
module byte_port_pins
  import byte_port_pkg::*;
(
  input  wire logic  i_ref_clk,  // Clock
  input  wire byte_t i_oe,       // Port drives
  input  wire byte_t i_out,      // Port level
  input  wire byte_t i_pu,       // Pull-up on
  input  wire byte_t i_ext,      // Board level
  input  wire byte_t i_ext_en,   // Board drives
  output byte_t      o_level     // Pad level
);
  byte_t flt_reg = 8'h55;
  // Undriven pads without pull-up wander so they never pass for a held value
  always @(posedge i_ref_clk) flt_reg <= ~flt_reg;
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pu | flt_reg));
endmodule : byte_port_pins
`default_nettype wire

// File: tb/byte_port_tb.sv
// Self-checking bench for the byte port
`timescale 1ns/1ps
`default_nettype none
`include "byte_port_map.svh"
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, v); end end
module byte_port_tb import byte_port_pkg::*;;
  logic ref_clk = 0, rst = 1, hw = 0, sw = 0, wr_stb = 0, rd_stb = 0, owned;
  logic [19:0] addr = '0;
  byte_t wdata = '0, bus_out = '0, bus_oe = '0, ext = 8'h5a, ext_en = 8'hff;
  byte_t pin, rdata, pin_out, pin_oe, pu, bus_in;
  int n_errors = 0, num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  byte_port i_byte_port (.i_ref_clk(ref_clk), .i_rst(rst), .i_hw_standby(hw), .i_sw_standby(sw), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_pin_in(pin), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pullup_on(pu), .i_bus_out(bus_out), .i_bus_oe(bus_oe), .o_bus_in(bus_in),
    .o_gpio_owned(owned));
  byte_port_pins i_byte_port_pins (.i_ref_clk(ref_clk), .i_oe(pin_oe), .i_out(pin_out), .i_pu(pu), .i_ext(ext),
    .i_ext_en(ext_en), .o_level(pin));
  task automatic wr(input logic [19:0] a, input byte_t d);
    @(posedge ref_clk) begin addr <= a; wdata <= d; wr_stb <= 1'b1; end
    @(posedge ref_clk) wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, output byte_t d);
    @(posedge ref_clk) begin addr <= a; rd_stb <= 1'b1; end
    @(posedge ref_clk) rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic t_reset;
    byte_t d;
    #1 `CHK("oe", 8'h00, pin_oe)
    rd(`PIN_DIRECTION_OFS, d); `CHK("dir", 8'hff, d)
    rd(`PIN_OUTPUT_DATA_OFS, d); `CHK("data", 8'h5a, d)
    rd(`PULLUP_ENABLE_OFS, d); `CHK("pu reg", 8'h00, d)
  endtask : t_reset
  task automatic t_gpio;
    byte_t d;
    @(posedge ref_clk) ext <= 8'h3c;
    wr(`PIN_DIRECTION_OFS, 8'hff); #1 `CHK("out", 8'h00, pin_out)
    wr(`PIN_DIRECTION_OFS, 8'h0f);
    wr(`PIN_OUTPUT_DATA_OFS, 8'ha5);
    wr(`PULLUP_ENABLE_OFS, 8'hf0);
    #1 `CHK("oe", 8'h0f, pin_oe)
    `CHK("out", 8'h05, pin_out & pin_oe)
    `CHK("pu", 8'hf0, pu)
    rd(`PIN_OUTPUT_DATA_OFS, d); `CHK("data", 8'h35, d)
    rd(`PULLUP_ENABLE_OFS, d); `CHK("pu reg", 8'hf0, d)
    rd(20'hee004, d); `CHK("unmapped", 8'h00, d)
  endtask : t_gpio
  task automatic t_sw;
    byte_t d;
    @(posedge ref_clk) sw <= 1'b1;
    rd(`PIN_OUTPUT_DATA_OFS, d); `CHK("data", 8'h35, d)
    `CHK("oe", 8'h0f, pin_oe)
    `CHK("pu", 8'hf0, pu)
    @(posedge ref_clk) sw <= 1'b0;
  endtask : t_sw
  task automatic t_bus;
    @(posedge ref_clk) begin bus_oe <= 8'h33; bus_out <= 8'hcc; end
    wr(`PORT_MODE_OFS, 8'h02); #1 `CHK("oe", 8'h33, pin_oe)
    `CHK("out", 8'hcc, pin_out)
    `CHK("bus in", 8'h0c, bus_in)
    `CHK("pu", 8'h00, pu)
    wr(`PORT_MODE_OFS, 8'h03); #1 `CHK("oe", 8'h0f, pin_oe)
    wr(`PORT_MODE_OFS, 8'h00); #1 `CHK("oe", 8'h0f, pin_oe)
  endtask : t_bus
  task automatic t_hw;
    byte_t d;
    @(posedge ref_clk) hw <= 1'b1;
    #1 `CHK("pu", 8'h00, pu)
    @(posedge ref_clk) hw <= 1'b0;
    #1 `CHK("oe", 8'h00, pin_oe)
    rd(`PULLUP_ENABLE_OFS, d); `CHK("pu reg", 8'h00, d)
    wr(`PIN_DIRECTION_OFS, 8'hff); #1 `CHK("out", 8'h00, pin_out)
  endtask : t_hw
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_gpio;
    t_sw;
    t_bus;
    t_hw;
    conclude;
  end
  initial begin
    #50000;
    n_errors++;
    conclude;
  end
endmodule : byte_port_tb
`default_nettype wire
